// ===== rtl/dcf_pkg.sv
/*
  constants and carrier types for one channel of the dual-clock FIFO:
  depth, pointer widths, offset defaults, register map and pin bundle.
  assumes a single system clock; all pins are sampled into that clock.
*/
package dcf_pkg;

  // ****************************************
  // sizes
  // ****************************************
  localparam int DW = 9;
  localparam int AW = 8;
  localparam int PW = 9;
  localparam logic [PW-1:0] DEPTH = 9'h100;
  localparam logic [7:0] OFFS_RST = 8'h07;
  localparam logic [7:0] OFFS_MSB_RST = 8'h00;
  localparam logic [1:0] OFFS_EMPTY_LO = 2'h0;
  localparam logic [1:0] OFFS_FULL_LO = 2'h2;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [31:0] ADDR_STATUS = 32'h0000_0000;
  localparam logic [31:0] ADDR_OFFSET = 32'h0000_0004;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
  localparam int ST_FULL = 9;
  localparam int ST_AFULL = 10;
  localparam int ST_AEMPTY = 11;
  localparam int ST_EMPTY = 12;
  localparam int ST_DUAL = 13;
  localparam int OF_FULL = 8;

  // ****************************************
  // pin bundle
  // ****************************************
  typedef struct packed {
    logic wclk;
    logic rclk;
    logic write_gate_one_n;
    logic write_gate_two_ld;
    logic ren1_n;
    logic ren2_n;
    logic oe_n;
    logic [DW-1:0] d;
  } dcf_pins_s;

endpackage

// ===== rtl/dcf_fifo_channel.sv
/*
  one channel of the dual-clock FIFO with status flags and offset registers.
  assumes write_clock and read_clock are pins far slower than clk; every pin
  is resampled by two flip-flops and its clock edges become enable pulses.
*/
// Summary of operation
// - zero words: full high, almost-full high, others low
// - one to n words: empty high, almost-empty low
// - depth-m to depth-1: almost-full low, full high
// - depth words: full and almost-full both low
// - between offsets: all four flags high
// - strap pin latched at reset selects mode
// - after reset data low, output enable controls drive
// - free-running clocks during reset are tolerated
// - full may lag one write edge
// - empty may lag one read edge
// - first word latency two reads; the first only clears empty
// - latency applies only at empty boundary
// - either inactive write enable blocks writes
// - almost-full may lag one write edge
// - almost-empty may lag one read edge
// - write at almost-full leaves depth minus m-1
// - read at almost-empty leaves n-1 words
// - write flags on write edges, read on read
// - write needs enable one low, two high
// - read needs both read enables low, not empty
// - load writes offsets in turn, wraps after four
`timescale 1ns/1ps
module dcf_fifo_channel
  import dcf_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic write_clock,
  input wire logic read_clock,
  input wire logic first_write_enable_n,
  input wire logic second_write_enable_or_load,
  input wire logic first_read_enable_n,
  input wire logic second_read_enable_n,
  input wire logic output_drive_enable_n,
  input wire logic [DW-1:0] write_data,
  output logic [DW-1:0] read_data_out,
  output logic read_data_oe_n,
  output logic full_indicator_n,
  output logic almost_full_indicator_n,
  output logic almost_empty_indicator_n,
  output logic empty_indicator_n,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  function automatic logic [PW-1:0] g2b(input logic [PW-1:0] g);
    logic [PW-1:0] b;
    b[PW-1] = g[PW-1];
    for (int i = PW - 2; i >= 0; i--)
    begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction

  // ****************************************
  // pin sampling
  // ****************************************
  dcf_pins_s pin_raw, s1_ff, s2_ff;
  logic wclk_d_ff, rclk_d_ff;
  logic wr_edge, rd_edge;

  assign pin_raw = {write_clock, read_clock, first_write_enable_n,
                    second_write_enable_or_load, first_read_enable_n,
                    second_read_enable_n, output_drive_enable_n, write_data};

  // clocks keep running through reset; only edges after release act
  always_ff @(posedge clk)
  begin
    s1_ff <= pin_raw;
    s2_ff <= s1_ff;
  end

  always_ff @(posedge clk)
  begin
    wclk_d_ff <= s2_ff.wclk;
    rclk_d_ff <= s2_ff.rclk;
  end

  assign wr_edge = s2_ff.wclk & ~wclk_d_ff & ~sys_rst;
  assign rd_edge = s2_ff.rclk & ~rclk_d_ff & ~sys_rst;

  // ****************************************
  // mode strap
  // ****************************************
  logic dual_ff;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      dual_ff <= s2_ff.write_gate_two_ld;
  end

  // ****************************************
  // storage and pointers
  // ****************************************
  logic [DW-1:0] mem [0:(1<<AW)-1];
  logic [PW-1:0] wbin_ff, wgray_ff, rbin_ff, rgray_ff;
  logic [PW-1:0] rg_s1_ff, rg_s2_ff, wg_s1_ff, wg_s2_ff;
  logic [PW-1:0] wcnt, wcnt_nx, rcnt, rcnt_nx, wbin_nx, rbin_nx;
  logic [7:0] offs_ff [0:3];
  logic [1:0] widx_ff, ridx_ff;
  logic wr_go, rd_go, offs_wr, offs_rd, rd_both;

  // skew between the two edges shows only as extra sync delay
  always_ff @(posedge clk)
  begin
    rg_s1_ff <= rgray_ff;
    rg_s2_ff <= rg_s1_ff;
    wg_s1_ff <= wgray_ff;
    wg_s2_ff <= wg_s1_ff;
  end

  assign wcnt = wbin_ff - g2b(rg_s2_ff);
  assign rcnt = g2b(wg_s2_ff) - rbin_ff;
  // enable two must be high in both modes; low means blocked or load
  assign wr_go = wr_edge & ~s2_ff.write_gate_one_n & s2_ff.write_gate_two_ld & (wcnt != DEPTH);
  assign offs_wr = wr_edge & ~dual_ff & ~s2_ff.write_gate_one_n & ~s2_ff.write_gate_two_ld;
  assign rd_both = ~s2_ff.ren1_n & ~s2_ff.ren2_n;
  // reads wait for the registered empty flag, as the reader sees it
  assign rd_go = rd_edge & rd_both & empty_indicator_n & (dual_ff | s2_ff.write_gate_two_ld);
  assign offs_rd = rd_edge & rd_both & ~dual_ff & ~s2_ff.write_gate_two_ld;
  assign wbin_nx = wbin_ff + {{(PW-1){1'b0}}, wr_go};
  assign rbin_nx = rbin_ff + {{(PW-1){1'b0}}, rd_go};
  assign wcnt_nx = wcnt + {{(PW-1){1'b0}}, wr_go};
  assign rcnt_nx = rcnt - {{(PW-1){1'b0}}, rd_go};

  always_ff @(posedge clk)
  begin
    if (wr_go)
      mem[wbin_ff[AW-1:0]] <= s2_ff.d;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      wbin_ff <= '0;
      wgray_ff <= '0;
    end
    else
    begin
      wbin_ff <= wbin_nx;
      wgray_ff <= wbin_nx ^ (wbin_nx >> 1);
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      rbin_ff <= '0;
      rgray_ff <= '0;
    end
    else
    begin
      rbin_ff <= rbin_nx;
      rgray_ff <= rbin_nx ^ (rbin_nx >> 1);
    end
  end

  // ****************************************
  // status flags
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      full_indicator_n <= 1'b1;
      almost_full_indicator_n <= 1'b1;
    end
    else if (wr_edge)
    begin
      full_indicator_n <= (wcnt_nx != DEPTH);
      almost_full_indicator_n <= (wcnt_nx < DEPTH - {1'b0, offs_ff[OFFS_FULL_LO]});
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      empty_indicator_n <= 1'b0;
      almost_empty_indicator_n <= 1'b0;
    end
    else if (rd_edge)
    begin
      empty_indicator_n <= (rcnt_nx != '0);
      almost_empty_indicator_n <= (rcnt_nx > {1'b0, offs_ff[OFFS_EMPTY_LO]});
    end
  end

  // ****************************************
  // offset registers
  // ****************************************
  logic axi_wr_offs;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      offs_ff[0] <= OFFS_RST;
      offs_ff[1] <= OFFS_MSB_RST;
      offs_ff[2] <= OFFS_RST;
      offs_ff[3] <= OFFS_MSB_RST;
      widx_ff <= 2'h0;
    end
    else if (offs_wr)
    begin
      offs_ff[widx_ff] <= s2_ff.d[7:0];
      widx_ff <= widx_ff + 2'h1;
    end
    else if (axi_wr_offs)
    begin
      if (wstrb_ff[0])
        offs_ff[OFFS_EMPTY_LO] <= wdata_ff[7:0];
      if (wstrb_ff[1])
        offs_ff[OFFS_FULL_LO] <= wdata_ff[OF_FULL+7:OF_FULL];
    end
  end

  // ****************************************
  // read port
  // ****************************************
  logic [DW-1:0] q_ff;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      q_ff <= '0;
      ridx_ff <= 2'h0;
    end
    else if (rd_go)
      q_ff <= mem[rbin_ff[AW-1:0]];
    else if (offs_rd)
    begin
      q_ff <= {1'b0, offs_ff[ridx_ff]};
      ridx_ff <= ridx_ff + 2'h1;
    end
  end

  assign read_data_out = q_ff;
  assign read_data_oe_n = s2_ff.oe_n;

  // ****************************************
  // register bus
  // ****************************************
  logic aw_got_ff, w_got_ff, wr_fire, bvalid_ff, rvalid_ff;
  logic [31:0] awaddr_ff, rdata_ff, status;
  logic [1:0] bresp_ff, rresp_ff;

  assign s_axi_awready = ~aw_got_ff & ~bvalid_ff;
  assign s_axi_wready = ~w_got_ff & ~bvalid_ff;
  assign s_axi_arready = ~rvalid_ff;
  assign wr_fire = aw_got_ff & w_got_ff & ~bvalid_ff;
  assign axi_wr_offs = wr_fire & ({awaddr_ff[31:2], 2'b00} == ADDR_OFFSET);
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

  always_comb
  begin
    status = '0;
    status[PW-1:0] = wcnt;
    status[ST_FULL] = full_indicator_n;
    status[ST_AFULL] = almost_full_indicator_n;
    status[ST_AEMPTY] = almost_empty_indicator_n;
    status[ST_EMPTY] = empty_indicator_n;
    status[ST_DUAL] = dual_ff;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OK;
      awaddr_ff <= '0;
      wdata_ff <= '0;
      wstrb_ff <= '0;
    end
    else
    begin
      if (s_axi_awvalid & s_axi_awready)
      begin
        aw_got_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready)
      begin
        w_got_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        aw_got_ff <= 1'b0;
        w_got_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff <= axi_wr_offs ? RESP_OK : RESP_ERR;
      end
      else if (bvalid_ff & s_axi_bready)
        bvalid_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      rvalid_ff <= 1'b0;
      rdata_ff <= '0;
      rresp_ff <= RESP_OK;
    end
    else if (s_axi_arvalid & s_axi_arready)
    begin
      rvalid_ff <= 1'b1;
      rresp_ff <= RESP_OK;
      unique case ({s_axi_araddr[31:2], 2'b00})
        ADDR_STATUS: rdata_ff <= status;
        ADDR_OFFSET: rdata_ff <= {16'h0000, offs_ff[OFFS_FULL_LO], offs_ff[OFFS_EMPTY_LO]};
        default:
        begin
          rdata_ff <= '0;
          rresp_ff <= RESP_ERR;
        end
      endcase
    end
    else if (rvalid_ff & s_axi_rready)
      rvalid_ff <= 1'b0;
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  property p_empty_zero;
    rd_edge |=> (empty_indicator_n == ($past(rcnt_nx) != '0));
  endproperty
  a_empty_zero: assert property (p_empty_zero) else $error("empty flag off count");
  property p_low_band;
    rd_edge && rcnt_nx != '0 && rcnt_nx <= {1'b0, offs_ff[0]}
      |=> empty_indicator_n && !almost_empty_indicator_n;
  endproperty
  a_low_band: assert property (p_low_band) else $error("low band flags wrong");
  property p_high_band;
    wr_edge && wcnt_nx != DEPTH && wcnt_nx >= DEPTH - {1'b0, offs_ff[2]}
      |=> full_indicator_n && !almost_full_indicator_n;
  endproperty
  a_high_band: assert property (p_high_band) else $error("high band flags wrong");
  property p_full;
    wr_edge && wcnt_nx == DEPTH |=> !full_indicator_n && !almost_full_indicator_n;
  endproperty
  a_full: assert property (p_full) else $error("full flags wrong");
  property p_mid;
    rd_edge && rcnt_nx > {1'b0, offs_ff[0]} |=> almost_empty_indicator_n && empty_indicator_n;
  endproperty
  a_mid: assert property (p_mid) else $error("mid band flags wrong");
  property p_wr_flags_hold;
    !wr_edge |=> $stable(full_indicator_n) && $stable(almost_full_indicator_n);
  endproperty
  a_wr_flags_hold: assert property (p_wr_flags_hold) else $error("write flag moved");
  property p_blocked;
    wr_edge && (s2_ff.write_gate_one_n || !s2_ff.write_gate_two_ld) |=> $stable(wbin_ff);
  endproperty
  a_blocked: assert property (p_blocked) else $error("write not blocked");
  property p_no_read_empty;
    rd_edge && !empty_indicator_n && !offs_rd |=> $stable(q_ff) && $stable(rbin_ff);
  endproperty
  a_no_read_empty: assert property (p_no_read_empty) else $error("read from empty");
  property p_offs_seq;
    offs_wr |=> widx_ff == $past(widx_ff) + 2'h1;
  endproperty
  a_offs_seq: assert property (p_offs_seq) else $error("offset index wrong");
  property p_gray;
    ##1 $countones(wgray_ff ^ $past(wgray_ff)) <= 1;
  endproperty
  a_gray: assert property (p_gray) else $error("gray pointer jumped");

  c_full: cover property (wr_edge && wcnt_nx == DEPTH);
  c_first_word: cover property (!empty_indicator_n ##[1:40] rd_go);
  c_offs_load: cover property (offs_wr ##[1:40] offs_wr);
  c_axi_wr: cover property (axi_wr_offs);

endmodule // dcf_fifo_channel

// ===== bench/dcf_far_model.sv
/*
  writer and reader logic that stands at the pins of one fifo channel.
  assumes clk is the system clock; pins change just after its rising edge.
*/
`timescale 1ns/1ps
module dcf_far_model
  import dcf_pkg::*;
(
  input wire logic clk,
  output dcf_pins_s pins
);
  initial pins = '{wclk: 1'b0, rclk: 1'b0, write_gate_one_n: 1'b1, write_gate_two_ld: 1'b1, ren1_n: 1'b1,
                   ren2_n: 1'b1, oe_n: 1'b0, d: '0};

  // ****************************************
  // pin clock pulses
  // ****************************************
  task automatic pulse(input logic on_read);
    repeat (4) @(posedge clk);
    if (on_read) pins.rclk <= 1'b1;
    else pins.wclk <= 1'b1;
    repeat (4) @(posedge clk);
    if (on_read) pins.rclk <= 1'b0;
    else pins.wclk <= 1'b0;
  endtask

  task automatic spin(input int n);
    repeat (n)
    begin
      pins.wclk <= 1'b1;
      pins.rclk <= 1'b1;
      repeat (3) @(posedge clk);
      pins.wclk <= 1'b0;
      pins.rclk <= 1'b0;
      repeat (3) @(posedge clk);
    end
  endtask

  // ****************************************
  // word transfers
  // ****************************************
  task automatic wr(input logic [DW-1:0] dv, input logic e1n, input logic e2);
    @(posedge clk);
    pins.d <= dv;
    pins.write_gate_one_n <= e1n;
    pins.write_gate_two_ld <= e2;
    pulse(1'b0);
    repeat (4) @(posedge clk);
    pins.write_gate_one_n <= 1'b1;
    pins.d <= ~dv;
  endtask

  task automatic rd(input logic r1n, input logic r2n);
    @(posedge clk);
    pins.ren1_n <= r1n;
    pins.ren2_n <= r2n;
    pulse(1'b1);
    repeat (4) @(posedge clk);
    pins.ren1_n <= 1'b1;
    pins.ren2_n <= 1'b1;
  endtask

  task automatic strap(input logic v);
    @(posedge clk);
    pins.write_gate_two_ld <= v;
  endtask

  task automatic drive_oe(input logic v);
    @(posedge clk);
    pins.oe_n <= v;
  endtask
endmodule // dcf_far_model

// ===== bench/dcf_fifo_channel_tb.sv
/*
  self-checking bench for one fifo channel: pin traffic through the far
  model, offset and status registers through an axi4-lite master.
  assumes the design's package and a 25 mhz system clock.
*/
`timescale 1ns/1ps
module dcf_fifo_channel_tb
  import dcf_pkg::*;
;
  logic clk, sys_rst, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, oe_n, full_n, afull_n, aempty_n, empty_n;
  logic [31:0] awaddr, wdata, araddr, rdata, v;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  logic [DW-1:0] q;
  dcf_pins_s pins;
  int n_errors, n_checks, k;

  dcf_far_model far (.clk(clk), .pins(pins));
  dcf_fifo_channel dut (.clk(clk), .sys_rst(sys_rst), .write_clock(pins.wclk),
    .read_clock(pins.rclk), .first_write_enable_n(pins.write_gate_one_n),
    .second_write_enable_or_load(pins.write_gate_two_ld), .first_read_enable_n(pins.ren1_n),
    .second_read_enable_n(pins.ren2_n), .output_drive_enable_n(pins.oe_n),
    .write_data(pins.d), .read_data_out(q), .read_data_oe_n(oe_n),
    .full_indicator_n(full_n), .almost_full_indicator_n(afull_n),
    .almost_empty_indicator_n(aempty_n), .empty_indicator_n(empty_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ****************************************
  // compare and report
  // ****************************************
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk_bit(input string nm, input logic e, input logic g);
    n_checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("unexpected %s expected=%b seen=%b", nm, e, g);
    end
  endtask

  task automatic chk_val(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("unexpected %s expected=%h seen=%h", nm, e, g);
    end
  endtask

  task automatic stuck(input string nm);
    n_errors++;
    $display("unexpected %s expected=answer seen=none", nm);
    conclude();
  endtask

  function automatic logic [DW-1:0] word_of(input int n);
    return ~n[DW-1:0];
  endfunction

  // ****************************************
  // axi4-lite master
  // ****************************************
  task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] rs);
    bit done;
    done = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int i = 0; i < 50 && !done; i++)
    begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1)
      begin
        rs = bresp;
        bready <= 1'b0;
        done = 1;
      end
    end
    if (!done) stuck("write_response");
  endtask

  task automatic axi_rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] rs);
    bit done;
    done = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int i = 0; i < 50 && !done; i++)
    begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1)
      begin
        d = rdata;
        rs = rresp;
        rready <= 1'b0;
        done = 1;
      end
    end
    if (!done) stuck("read_response");
  endtask

  task automatic do_reset(input logic mode);
    far.strap(mode);
    sys_rst <= 1'b1;
    far.spin(1);
    sys_rst <= 1'b0;
    @(posedge clk);
    chk_bit("full_n", 1'b1, full_n);
    chk_bit("almost_full_n", 1'b1, afull_n);
    chk_bit("almost_empty_n", 1'b0, aempty_n);
    chk_bit("empty_n", 1'b0, empty_n);
    chk_val("read_data", 32'h0, {23'h0, q});
  endtask

  // ****************************************
  // tests
  // ****************************************
  initial
  begin
    sys_rst = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, wdata, araddr} = '0;
    wstrb = 4'hf;
    n_errors = 0;
    n_checks = 0;
    do_reset(1'b1);
    far.drive_oe(1'b1);
    repeat (4) @(posedge clk);
    chk_bit("oe_n", 1'b1, oe_n);
    far.drive_oe(1'b0);
    repeat (4) @(posedge clk);
    chk_bit("oe_n", 1'b0, oe_n);
    $display("test reset done");
    far.wr(9'h1ff, 1'b1, 1'b1);
    far.wr(9'h1ff, 1'b0, 1'b0);
    axi_rd(ADDR_STATUS, v, r);
    chk_val("status", 32'h0000_2600, v);
    $display("test write gating done");
    far.wr(word_of(0), 1'b0, 1'b1);
    far.rd(1'b0, 1'b0);
    chk_val("read_data", 32'h0, {23'h0, q});
    chk_bit("empty_n", 1'b1, empty_n);
    chk_bit("almost_empty_n", 1'b0, aempty_n);
    far.rd(1'b0, 1'b1);
    chk_val("read_data", 32'h0, {23'h0, q});
    far.rd(1'b0, 1'b0);
    chk_val("read_data", {23'h0, word_of(0)}, {23'h0, q});
    chk_bit("empty_n", 1'b0, empty_n);
    $display("test first word done");
    for (k = 1; k <= 256; k++)
    begin
      far.wr(word_of(k), 1'b0, 1'b1);
      if (k == 7 || k == 8)
      begin
        far.rd(1'b1, 1'b1);
        chk_bit("almost_empty_n", k == 8, aempty_n);
      end
      if (k == 248 || k == 249 || k == 256)
      begin
        chk_bit("almost_full_n", k == 248, afull_n);
        chk_bit("full_n", k != 256, full_n);
      end
    end
    far.wr(9'h0aa, 1'b0, 1'b1);
    axi_rd(ADDR_STATUS, v, r);
    chk_val("status", 32'h0000_3900, v);
    $display("test fill done");
    axi_wr(ADDR_OFFSET, 32'h0000_0503, r);
    chk_val("bresp", {30'h0, RESP_OK}, {30'h0, r});
    axi_rd(ADDR_OFFSET, v, r);
    chk_val("offset", 32'h0000_0503, v);
    axi_wr(32'h0000_0010, 32'h0000_0001, r);
    chk_val("bresp", {30'h0, RESP_ERR}, {30'h0, r});
    axi_rd(32'h0000_0010, v, r);
    chk_val("rresp", {30'h0, RESP_ERR}, {30'h0, r});
    chk_val("rdata", 32'h0, v);
    $display("test registers done");
    for (k = 1; k <= 256; k++)
    begin
      far.rd(1'b0, 1'b0);
      chk_val("read_data", {23'h0, word_of(k)}, {23'h0, q});
      if (k == 252 || k == 253) chk_bit("almost_empty_n", k == 252, aempty_n);
      if (k == 255) chk_bit("empty_n", 1'b1, empty_n);
    end
    chk_bit("empty_n", 1'b0, empty_n);
    chk_bit("almost_empty_n", 1'b0, aempty_n);
    far.rd(1'b0, 1'b0);
    chk_val("read_data", {23'h0, word_of(256)}, {23'h0, q});
    $display("test drain done");
    do_reset(1'b0);
    far.wr(9'h002, 1'b0, 1'b0);
    far.wr(9'h000, 1'b0, 1'b0);
    far.wr(9'h004, 1'b0, 1'b0);
    far.wr(9'h000, 1'b0, 1'b0);
    axi_rd(ADDR_OFFSET, v, r);
    chk_val("offset", 32'h0000_0402, v);
    far.wr(9'h006, 1'b0, 1'b0);
    axi_rd(ADDR_OFFSET, v, r);
    chk_val("offset", 32'h0000_0406, v);
    far.rd(1'b0, 1'b0);
    chk_val("read_data", 32'h0000_0006, {23'h0, q});
    axi_rd(ADDR_STATUS, v, r);
    chk_val("status", 32'h0000_0600, v);
    $display("test load mode done");
    conclude();
  end
endmodule // dcf_fifo_channel_tb
